// [rtl/mcap_pkg.sv]
`default_nettype none
package mcap_pkg;
  // ************************************************************
  // clock and timing
  // ************************************************************
  localparam longint unsigned CLK_HZ = 64'd25000000;
  localparam longint unsigned T_OFF_MS = 64'd1;
  localparam longint unsigned T_ON_S = 64'd25;
  localparam longint unsigned T_LOPWR_S = 64'd25;
  localparam longint unsigned T_INIT_MIN_S = 64'd190;
  localparam longint unsigned T_INIT_MAX_S = 64'd220;
  localparam longint unsigned T_LOS_ON_MS = 64'd1;
  localparam longint unsigned T_LOS_OFF_MS = 64'd15;
  localparam longint unsigned T_LOS_HOLD_MS = 64'd10;
  localparam longint unsigned MDC_MAX_HZ = 64'd4000000;
  localparam int CNT_W = 40;
  // least time: round up
  localparam longint unsigned INIT_CYC = T_INIT_MIN_S * CLK_HZ;
  localparam longint unsigned LOS_HOLD_CYC = (T_LOS_HOLD_MS * CLK_HZ + 64'd999) / 64'd1000;
  // shortest legal mdc half period, rounded down
  localparam longint unsigned MDC_HALF_CYC = CLK_HZ / (64'd2 * MDC_MAX_HZ);
  localparam logic [3:0] MDC_MIN_PHASE = 4'(MDC_HALF_CYC - 64'd1);
  localparam logic [3:0] MDC_PHASE_MAX = 4'hf;
  // ************************************************************
  // monitor clock divider
  // ************************************************************
  localparam int MCLK_RATIO = 48;
  localparam logic [4:0] MCLK_HALF = 5'(MCLK_RATIO / 2);
  // ************************************************************
  // register map
  // ************************************************************
  localparam int ADDR_W = 8;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_IRQ_STAT = 8'h08;
  localparam logic [7:0] REG_IRQ_MASK = 8'h0c;
  localparam logic [1:0] CTRL_RST = 2'h0;
  localparam int CTRL_FORCE_OFF = 0;
  localparam int CTRL_FORCE_LP = 1;
  localparam int EV_LOS_SET = 0;
  localparam int EV_LOS_CLR = 1;
  localparam int EV_INIT_DONE = 2;
  localparam int EV_MDC_FAST = 3;
  localparam int EV_N = 4;
  localparam logic [3:0] MASK_RST = 4'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [2:0] {
    ST_RESET = 3'b000,
    ST_INIT = 3'b001,
    ST_LOPWR = 3'b010,
    ST_RUN = 3'b011
  } mcap_state_t;
endpackage
`default_nettype wire

// [rtl/mcap_top.sv]
`default_nettype none
// Contract
// - transmit disable high turns the laser off within 1 ms.
// - transmit disable low turns the laser on within 25 s.
// - low-power request high enters and holds low power mode within 25 s.
// - low-power request low brings the module to normal high power within 25 s.
// - low power mode keeps management alive and stays at or below 2 W.
// - module reset held low keeps the module in reset.
// - reset release runs initialization lasting 190 to 220 s.
// - receive loss output high while received power is too low.
// - receive loss output asserts within 1 ms of low power.
// - receive loss output clears within 15 ms of power returning.
// - presence output is tied low inside the module.
// - transmit monitor clock runs at one forty-eighth of the symbol rate.
// - timing comes from the internal local clock, no host reference clock.
// - management access uses clause 45 MDIO framing.
// - management link runs at up to 4 Mb/s and must be accepted.
// - an unconnected transmit disable reads high, laser off by default.
// - an unconnected low-power request reads high, low power by default.
module mcap_top #(
  parameter logic [39:0] INIT_CYCLES = 40'(mcap_pkg::INIT_CYC),
  parameter logic [39:0] LOS_HOLD_CYCLES = 40'(mcap_pkg::LOS_HOLD_CYC)
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic laser_output_off_i,
  input wire logic low_power_request_i,
  input wire logic module_reset_low_i,
  input wire logic rx_power_low_i,
  input wire logic symbol_tick_i,
  input wire logic mdc_i,
  input wire logic mdio_i,
  output logic laser_enable_o,
  output logic high_power_enable_o,
  output logic mgmt_enable_o,
  output logic mgmt_mdc_o,
  output logic mgmt_mdio_o,
  output logic receive_signal_lost_o,
  output logic presence_indicator_o,
  output logic transmit_monitor_clock_o,
  output logic irq_o,
  input wire logic [mcap_pkg::ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [mcap_pkg::ADDR_W-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i
);
  import mcap_pkg::*;

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  // pull-up pins reset to one so a floating pin means safe
  localparam logic [5:0] SYNC_RST = 6'h03;
  logic [5:0] pin_raw;
  logic [5:0] sync1_q;
  logic [5:0] sync2_q;
  assign pin_raw = {mdio_i, mdc_i, rx_power_low_i, module_reset_low_i,
                    low_power_request_i, laser_output_off_i};

  genvar gi;
  generate
    for (gi = 0; gi < 6; gi++) begin : g_sync
      always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
          sync1_q[gi] <= SYNC_RST[gi];
          sync2_q[gi] <= SYNC_RST[gi];
        end else begin
          sync1_q[gi] <= pin_raw[gi];
          sync2_q[gi] <= sync1_q[gi];
        end
      end
    end
  endgenerate

  logic dis_s;
  logic lp_s;
  logic rstn_s;
  logic los_s;
  logic mdc_s;
  logic mdio_s;
  assign dis_s = sync2_q[0];
  assign lp_s = sync2_q[1];
  assign rstn_s = sync2_q[2];
  assign los_s = sync2_q[3];
  assign mdc_s = sync2_q[4];
  assign mdio_s = sync2_q[5];

  logic [1:0] ctrl_q;
  logic [EV_N-1:0] irq_stat_q;
  logic [EV_N-1:0] irq_mask_q;
  logic [EV_N-1:0] ev;

  // ************************************************************
  // power and reset sequencer
  // ************************************************************
  mcap_state_t state_q;
  logic [39:0] init_cnt_q;
  logic want_lp;
  assign want_lp = lp_s | ctrl_q[CTRL_FORCE_LP];

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      state_q <= ST_RESET;
    end else if (!rstn_s) begin
      state_q <= ST_RESET;
    end else begin
      case (state_q)
        ST_RESET: begin
          state_q <= ST_INIT;
        end
        ST_INIT: begin
          if (init_cnt_q == INIT_CYCLES - 40'h1) begin
            state_q <= want_lp ? ST_LOPWR : ST_RUN;
          end
        end
        ST_LOPWR: begin
          if (!want_lp) begin
            state_q <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (want_lp) begin
            state_q <= ST_LOPWR;
          end
        end
        default: begin
          state_q <= ST_RESET;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      init_cnt_q <= 40'h0;
    end else if (state_q != ST_INIT) begin
      init_cnt_q <= 40'h0;
    end else begin
      init_cnt_q <= init_cnt_q + 40'h1;
    end
  end

  // rails for the high power domain only come up in normal mode,
  // which is what keeps low power mode inside its budget
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      high_power_enable_o <= 1'b0;
      mgmt_enable_o <= 1'b0;
    end else begin
      high_power_enable_o <= (state_q == ST_RUN);
      mgmt_enable_o <= (state_q != ST_RESET);
    end
  end

  // ************************************************************
  // laser control
  // ************************************************************
  // turn-off reacts within a few cycles, far inside the off time
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      laser_enable_o <= 1'b0;
    end else begin
      laser_enable_o <= (state_q == ST_RUN) && !dis_s
                        && !ctrl_q[CTRL_FORCE_OFF];
    end
  end

  // ************************************************************
  // receive loss of signal
  // ************************************************************
  // clearing waits for a steady good level so a flickering input
  // does not chatter the pin
  logic [39:0] los_hold_q;
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      receive_signal_lost_o <= 1'b1;
      los_hold_q <= 40'h0;
    end else if (los_s) begin
      receive_signal_lost_o <= 1'b1;
      los_hold_q <= 40'h0;
    end else if (receive_signal_lost_o) begin
      if (los_hold_q == LOS_HOLD_CYCLES - 40'h1) begin
        receive_signal_lost_o <= 1'b0;
        los_hold_q <= 40'h0;
      end else begin
        los_hold_q <= los_hold_q + 40'h1;
      end
    end
  end

  // ************************************************************
  // presence and monitor clock
  // ************************************************************
  always_ff @(posedge sys_clk_i) begin
    presence_indicator_o <= 1'b0;
  end

  // symbol ticks come from the transmit datapath on the internal
  // local clock; no host reference clock is used
  logic [4:0] mclk_cnt_q;
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      mclk_cnt_q <= 5'h0;
      transmit_monitor_clock_o <= 1'b0;
    end else if (symbol_tick_i) begin
      if (mclk_cnt_q == MCLK_HALF - 5'h1) begin
        mclk_cnt_q <= 5'h0;
        transmit_monitor_clock_o <= !transmit_monitor_clock_o;
      end else begin
        mclk_cnt_q <= mclk_cnt_q + 5'h1;
      end
    end
  end

  // ************************************************************
  // management pins
  // ************************************************************
  // frames are decoded by the clause 45 engine behind these outputs
  logic mdc_d1_q;
  logic [3:0] mdc_phase_q;
  logic mdc_edge;
  assign mdc_edge = mdc_s ^ mdc_d1_q;
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      mgmt_mdc_o <= 1'b0;
      mgmt_mdio_o <= 1'b1;
      mdc_d1_q <= 1'b0;
      mdc_phase_q <= MDC_PHASE_MAX;
    end else begin
      mgmt_mdc_o <= mdc_s;
      mgmt_mdio_o <= mdio_s;
      mdc_d1_q <= mdc_s;
      if (mdc_edge) begin
        mdc_phase_q <= 4'h0;
      end else if (mdc_phase_q != MDC_PHASE_MAX) begin
        mdc_phase_q <= mdc_phase_q + 4'h1;
      end
    end
  end
  // phases shorter than the 4 Mb/s half period flag an overspeed host
  assign ev[EV_MDC_FAST] = mdc_edge && (mdc_phase_q < MDC_MIN_PHASE);

  // ************************************************************
  // interrupts
  // ************************************************************
  logic los_d1_q;
  logic init_d1_q;
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      los_d1_q <= 1'b1;
      init_d1_q <= 1'b0;
    end else begin
      los_d1_q <= receive_signal_lost_o;
      init_d1_q <= (state_q == ST_INIT);
    end
  end
  assign ev[EV_LOS_SET] = receive_signal_lost_o && !los_d1_q;
  assign ev[EV_LOS_CLR] = !receive_signal_lost_o && los_d1_q;
  assign ev[EV_INIT_DONE] = init_d1_q && (state_q != ST_INIT) && (state_q != ST_RESET);

  logic do_wr;
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic wr_lane0;
  assign wr_lane0 = do_wr && wstrb_q[0];

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      irq_stat_q <= '0;
    end else if (wr_lane0 && awaddr_q == REG_IRQ_STAT) begin
      // a new event wins over the clear in the same cycle
      irq_stat_q <= (irq_stat_q & ~wdata_q[EV_N-1:0]) | ev;
    end else begin
      irq_stat_q <= irq_stat_q | ev;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(irq_stat_q & irq_mask_q);
    end
  end

  // ************************************************************
  // axi4-lite slave
  // ************************************************************
  logic aw_held_q;
  logic w_held_q;
  assign do_wr = aw_held_q && w_held_q && !s_axi_bvalid_o;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      s_axi_awready_o <= 1'b1;
      s_axi_wready_o <= 1'b1;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= RESP_OKAY;
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
    end else begin
      if (s_axi_awready_o && s_axi_awvalid_i) begin
        aw_held_q <= 1'b1;
        awaddr_q <= s_axi_awaddr_i;
        s_axi_awready_o <= 1'b0;
      end
      if (s_axi_wready_o && s_axi_wvalid_i) begin
        w_held_q <= 1'b1;
        wdata_q <= s_axi_wdata_i;
        wstrb_q <= s_axi_wstrb_i;
        s_axi_wready_o <= 1'b0;
      end
      if (do_wr) begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o <= (awaddr_q == REG_CTRL || awaddr_q == REG_STATUS ||
                          awaddr_q == REG_IRQ_STAT || awaddr_q == REG_IRQ_MASK)
                         ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_bvalid_o && s_axi_bready_i) begin
        s_axi_bvalid_o <= 1'b0;
        s_axi_awready_o <= 1'b1;
        s_axi_wready_o <= 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      ctrl_q <= CTRL_RST;
      irq_mask_q <= MASK_RST;
    end else if (wr_lane0) begin
      if (awaddr_q == REG_CTRL) begin
        ctrl_q <= wdata_q[1:0];
      end
      if (awaddr_q == REG_IRQ_MASK) begin
        irq_mask_q <= wdata_q[EV_N-1:0];
      end
    end
  end

  logic [31:0] rd_mux;
  logic rd_hit;
  always_comb begin
    rd_mux = 32'h0;
    rd_hit = 1'b1;
    case (s_axi_araddr_i)
      REG_CTRL: rd_mux[1:0] = ctrl_q;
      REG_STATUS: rd_mux[7:0] = {laser_enable_o, receive_signal_lost_o,
                                 high_power_enable_o, mgmt_enable_o, 1'b0, state_q};
      REG_IRQ_STAT: rd_mux[EV_N-1:0] = irq_stat_q;
      REG_IRQ_MASK: rd_mux[EV_N-1:0] = irq_mask_q;
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      s_axi_arready_o <= 1'b1;
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= 32'h0;
      s_axi_rresp_o <= RESP_OKAY;
    end else if (s_axi_arready_o && s_axi_arvalid_i) begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o <= 1'b1;
      s_axi_rdata_o <= rd_mux;
      s_axi_rresp_o <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid_o && s_axi_rready_i) begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_arready_o <= 1'b1;
    end
  end

  // ************************************************************
  // assertions
  // ************************************************************
  property p_laser_off;
    @(posedge sys_clk_i) disable iff (rst_i)
      dis_s |=> !laser_enable_o;
  endproperty
  a_laser_off: assert property (p_laser_off) else $error("laser not off after disable");

  property p_laser_on;
    @(posedge sys_clk_i) disable iff (rst_i)
      (state_q == ST_RUN && !dis_s && !ctrl_q[CTRL_FORCE_OFF]) |=> laser_enable_o;
  endproperty
  a_laser_on: assert property (p_laser_on) else $error("laser not on when enabled");

  property p_enter_lp;
    @(posedge sys_clk_i) disable iff (rst_i)
      (state_q == ST_RUN && lp_s && rstn_s) |=> state_q == ST_LOPWR ##1 !high_power_enable_o;
  endproperty
  a_enter_lp: assert property (p_enter_lp) else $error("low power not entered");

  property p_leave_lp;
    @(posedge sys_clk_i) disable iff (rst_i)
      (state_q == ST_LOPWR && !want_lp && rstn_s) |=> state_q == ST_RUN ##1 high_power_enable_o;
  endproperty
  a_leave_lp: assert property (p_leave_lp) else $error("high power not entered");

  property p_mgmt_lp;
    @(posedge sys_clk_i) disable iff (rst_i)
      (state_q == ST_LOPWR) |=> mgmt_enable_o && !high_power_enable_o;
  endproperty
  a_mgmt_lp: assert property (p_mgmt_lp) else $error("low power mode rails wrong");

  property p_hold_reset;
    @(posedge sys_clk_i) disable iff (rst_i)
      !rstn_s |=> state_q == ST_RESET;
  endproperty
  a_hold_reset: assert property (p_hold_reset) else $error("left reset while held");

  property p_init_len;
    @(posedge sys_clk_i) disable iff (rst_i)
      ($past(state_q) == ST_INIT && state_q != ST_INIT && state_q != ST_RESET)
      |-> $past(init_cnt_q) == INIT_CYCLES - 40'h1;
  endproperty
  a_init_len: assert property (p_init_len) else $error("init length wrong");

  property p_los_on;
    @(posedge sys_clk_i) disable iff (rst_i)
      los_s |=> receive_signal_lost_o;
  endproperty
  a_los_on: assert property (p_los_on) else $error("loss not asserted");

  property p_los_off;
    @(posedge sys_clk_i) disable iff (rst_i)
      $fell(receive_signal_lost_o) |-> $past(los_hold_q) == LOS_HOLD_CYCLES - 40'h1;
  endproperty
  a_los_off: assert property (p_los_off) else $error("loss cleared early");

  property p_init_dark;
    @(posedge sys_clk_i) disable iff (rst_i)
      (state_q == ST_RESET || state_q == ST_INIT) |=> !laser_enable_o;
  endproperty
  a_init_dark: assert property (p_init_dark) else $error("laser on during init");

  property p_mclk;
    @(posedge sys_clk_i) disable iff (rst_i)
      $changed(transmit_monitor_clock_o)
      |-> $past(symbol_tick_i) && $past(mclk_cnt_q) == MCLK_HALF - 5'h1;
  endproperty
  a_mclk: assert property (p_mclk) else $error("monitor clock ratio wrong");

  property p_present;
    @(posedge sys_clk_i) disable iff (rst_i)
      ##1 !presence_indicator_o;
  endproperty
  a_present: assert property (p_present) else $error("presence not low");

endmodule
`default_nettype wire

// [verif/mcap_host_model.sv]
`default_nettype none
// ************************************************************
// host side of the control and alarm pins
// ************************************************************
module mcap_host_model (
  input wire logic clk_i,
  input wire logic want_off_i,
  input wire logic want_lp_i,
  input wire logic want_rst_n_i,
  input wire logic float_i,
  input wire logic tick_en_i,
  input wire logic presence_indicator_i,
  output logic laser_output_off_o,
  output logic low_power_request_o,
  output logic module_reset_low_o,
  output logic symbol_tick_o,
  output logic mdc_o,
  output logic mdio_o,
  output logic present_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] ph_q;
  // an open pin reads its pull level, so float means off and low power
  assign laser_output_off_o = float_i ? 1'b1 : want_off_i;
  assign low_power_request_o = float_i ? 1'b1 : want_lp_i;
  // reset stays wired: floating it would mask the float test
  assign module_reset_low_o = want_rst_n_i;
  // host pull-up: anything but a driven low reads absent
  assign present_o = (presence_indicator_i === 1'b0) ? 1'b0 : 1'b1;
  initial begin
    ph_q = 3'h0;
    mdc_o = 1'b0;
    mdio_o = 1'b1;
    symbol_tick_o = 1'b0;
  end
  // mdc half period of 4 cycles stays below the top link rate
  always @(posedge clk_i) begin
    ph_q <= ph_q + 3'h1;
    if (ph_q == 3'h3) mdc_o <= 1'b1;
    if (ph_q == 3'h7) begin
      mdc_o <= 1'b0;
      mdio_o <= 1'($urandom);
    end
    symbol_tick_o <= tick_en_i && ($urandom % 3 == 0);
  end
endmodule
`default_nettype wire

// [verif/mcap_top_tb_top.sv]
`default_nettype none
module mcap_top_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import mcap_pkg::*;
  // ************************************************************
  // short counts so the run stays brief
  // ************************************************************
  localparam int INIT_N = 50;
  localparam int HOLD_N = 20;
  logic sys_clk_i, rst_i, want_off, want_lp, want_rstn, flt, ten, present;
  logic laser_output_off_i, low_power_request_i, module_reset_low_i, rx_power_low_i;
  logic symbol_tick_i, mdc_i, mdio_i, laser_enable_o, high_power_enable_o, mgmt_enable_o;
  logic receive_signal_lost_o, presence_indicator_o, transmit_monitor_clock_o, irq_o;
  logic [7:0] s_axi_awaddr_i, s_axi_araddr_i;
  logic [31:0] s_axi_wdata_i, s_axi_rdata_o, v;
  logic [3:0] s_axi_wstrb_i;
  logic [1:0] s_axi_bresp_o, s_axi_rresp_o;
  logic s_axi_awvalid_i, s_axi_awready_o, s_axi_wvalid_i, s_axi_wready_o, s_axi_bvalid_o;
  logic s_axi_bready_i, s_axi_arvalid_i, s_axi_arready_o, s_axi_rvalid_o, s_axi_rready_i;
  logic mon_q, mon_seen, mgmt_mdc_o, mgmt_mdio_o;
  logic [5:0] mg_dl;
  int failures, checks, cyc, tcnt, n;
  mcap_top #(.INIT_CYCLES(40'(INIT_N)), .LOS_HOLD_CYCLES(40'(HOLD_N))) u_mcap_top (
    .sys_clk_i, .rst_i, .laser_output_off_i, .low_power_request_i, .module_reset_low_i,
    .rx_power_low_i, .symbol_tick_i, .mdc_i, .mdio_i, .laser_enable_o, .high_power_enable_o,
    .mgmt_enable_o, .mgmt_mdc_o, .mgmt_mdio_o, .receive_signal_lost_o,
    .presence_indicator_o, .transmit_monitor_clock_o, .irq_o, .s_axi_awaddr_i,
    .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_wvalid_i,
    .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i,
    .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o,
    .s_axi_rready_i);
  mcap_host_model u_mcap_host_model (
    .clk_i(sys_clk_i), .want_off_i(want_off), .want_lp_i(want_lp), .want_rst_n_i(want_rstn),
    .float_i(flt), .tick_en_i(ten), .presence_indicator_i(presence_indicator_o),
    .laser_output_off_o(laser_output_off_i), .low_power_request_o(low_power_request_i),
    .module_reset_low_o(module_reset_low_i), .symbol_tick_o(symbol_tick_i),
    .mdc_o(mdc_i), .mdio_o(mdio_i), .present_o(present));
  // ************************************************************
  // compare and expectation helpers
  // ************************************************************
  task automatic cmpb(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t level %b expected %b", $time, got, exp);
    end
  endtask
  task automatic cmpw(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t word %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmpn(input int got, input int lo, input int hi);
    checks++;
    if (got < lo || got > hi) begin
      failures++;
      $display("MISMATCH t=%0t count %0d outside %0d..%0d", $time, got, lo, hi);
    end
  endtask
  function automatic logic lvl(input int k);
    case (k)
      0: return laser_enable_o;
      1: return high_power_enable_o;
      2: return receive_signal_lost_o;
      default: return irq_o;
    endcase
  endfunction
  function automatic logic [31:0] stat_w(input logic [2:0] s, input logic [3:0] f);
    return {24'h0, f, 1'b0, s};
  endfunction
  function automatic logic [31:0] exp_mask(input logic [31:0] w);
    return {28'h0, w[3:0]};
  endfunction
  // counts edges until the chosen output reads val; one edge of sampling lag
  task automatic wt(input int k, input logic val, output int cnt);
    cnt = 0;
    while (lvl(k) !== val && cnt < 400) begin
      @(posedge sys_clk_i);
      cnt++;
    end
  endtask
  // ************************************************************
  // register bus master
  // ************************************************************
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ad;
    logic wd;
    ad = 1'b0;
    wd = 1'b0;
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= d;
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i <= 1'b1;
    s_axi_bready_i <= 1'b1;
    do begin
      @(posedge sys_clk_i);
      if (!ad && s_axi_awready_o === 1'b1) begin
        ad = 1'b1;
        s_axi_awvalid_i <= 1'b0;
      end
      if (!wd && s_axi_wready_o === 1'b1) begin
        wd = 1'b1;
        s_axi_wvalid_i <= 1'b0;
      end
    end while (!(ad && wd && s_axi_bvalid_o === 1'b1));
    s_axi_bready_i <= 1'b0;
    cmpw({30'h0, s_axi_bresp_o}, {30'h0, er});
    @(posedge sys_clk_i);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic ad;
    ad = 1'b0;
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1'b1;
    s_axi_rready_i <= 1'b1;
    do begin
      @(posedge sys_clk_i);
      if (!ad && s_axi_arready_o === 1'b1) begin
        ad = 1'b1;
        s_axi_arvalid_i <= 1'b0;
      end
    end while (!(ad && s_axi_rvalid_o === 1'b1));
    s_axi_rready_i <= 1'b0;
    cmpw(s_axi_rdata_o, ed);
    cmpw({30'h0, s_axi_rresp_o}, {30'h0, er});
    @(posedge sys_clk_i);
  endtask
  task automatic conclude();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    sys_clk_i = 1'b0;
    forever #20 sys_clk_i = ~sys_clk_i;
  end
  // intervals between monitor clock toggles; the first after an outage is skipped
  always @(posedge sys_clk_i) begin
    mon_q <= transmit_monitor_clock_o;
    if (rst_i || mgmt_enable_o !== 1'b1) begin
      tcnt <= 0;
      mon_seen <= 1'b0;
    end else if (transmit_monitor_clock_o !== mon_q) begin
      if (mon_seen) cmpn(tcnt, int'(MCLK_HALF), int'(MCLK_HALF));
      mon_seen <= 1'b1;
      tcnt <= int'(symbol_tick_i);
    end else
      tcnt <= tcnt + int'(symbol_tick_i);
  end
  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    mg_dl <= {mg_dl[3:0], mdc_i, mdio_i};
    if (cyc > 8) cmpw({30'h0, mgmt_mdc_o, mgmt_mdio_o}, {30'h0, mg_dl[5:4]});
    if (cyc == 20000) begin
      failures++;
      conclude();
    end
  end
  // ************************************************************
  // tests
  // ************************************************************
  initial begin
    {rst_i, want_off, want_lp, ten} = 4'hf;
    {want_rstn, flt, rx_power_low_i, s_axi_awvalid_i, s_axi_wvalid_i} = 5'h0;
    {s_axi_bready_i, s_axi_arvalid_i, s_axi_rready_i, mon_q, mon_seen} = 5'h0;
    {s_axi_awaddr_i, s_axi_araddr_i, s_axi_wdata_i} = 48'h0;
    s_axi_wstrb_i = 4'hf;
    {failures, checks, cyc, tcnt} = '0;
    v = $urandom(32'h7182fb79);
    repeat (5) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    @(posedge sys_clk_i);
    cmpb(laser_enable_o, 1'b0);
    cmpb(present, 1'b0);
    cmpb(irq_o, 1'b0);
    rd(REG_CTRL, 32'h0, RESP_OKAY);
    rd(REG_IRQ_MASK, {28'h0, MASK_RST}, RESP_OKAY);
    rd(8'h10, 32'h0, RESP_SLVERR);
    wr(8'h10, 32'h3, RESP_SLVERR);
    wr(REG_STATUS, 32'hff, RESP_OKAY);
    $display("test reset done");
    want_off <= 1'b0;
    want_lp <= 1'b0;
    repeat (30) @(posedge sys_clk_i);
    rd(REG_STATUS, stat_w(ST_RESET, 4'h0), RESP_OKAY);
    cmpb(laser_enable_o, 1'b0);
    want_rstn <= 1'b1;
    wt(0, 1'b1, n);
    cmpn(n - 1, INIT_N, INIT_N + 8);
    rd(REG_STATUS, stat_w(ST_RUN, 4'hb), RESP_OKAY);
    $display("test init done");
    want_lp <= 1'b1;
    wt(1, 1'b0, n);
    cmpn(n - 1, 3, 5);
    rd(REG_STATUS, stat_w(ST_LOPWR, 4'h1), RESP_OKAY);
    want_lp <= 1'b0;
    wt(1, 1'b1, n);
    cmpn(n - 1, 3, 5);
    wt(0, 1'b1, n);
    want_off <= 1'b1;
    wt(0, 1'b0, n);
    cmpn(n - 1, 3, 3);
    want_off <= 1'b0;
    wt(0, 1'b1, n);
    cmpn(n - 1, 3, 5);
    wr(REG_CTRL, 32'h1 << CTRL_FORCE_OFF, RESP_OKAY);
    cmpb(laser_enable_o, 1'b0);
    wr(REG_CTRL, 32'h0, RESP_OKAY);
    wt(0, 1'b1, n);
    $display("test power and disable done");
    flt <= 1'b1;
    wt(0, 1'b0, n);
    cmpn(n - 1, 3, 3);
    wt(1, 1'b0, n);
    cmpn(n, 0, 3);
    flt <= 1'b0;
    wt(0, 1'b1, n);
    $display("test open pins done");
    rd(REG_IRQ_STAT, (32'h1 << EV_LOS_CLR) | (32'h1 << EV_INIT_DONE), RESP_OKAY);
    wr(REG_IRQ_STAT, 32'hf, RESP_OKAY);
    wr(REG_IRQ_MASK, 32'h1 << EV_LOS_SET, RESP_OKAY);
    rx_power_low_i <= 1'b1;
    wt(2, 1'b1, n);
    cmpn(n - 1, 3, 3);
    wt(3, 1'b1, n);
    cmpn(n, 0, 3);
    rd(REG_IRQ_STAT, 32'h1 << EV_LOS_SET, RESP_OKAY);
    wr(REG_IRQ_MASK, 32'h0, RESP_OKAY);
    cmpb(irq_o, 1'b0);
    wr(REG_IRQ_MASK, 32'h1, RESP_OKAY);
    wr(REG_IRQ_STAT, 32'h1, RESP_OKAY);
    cmpb(irq_o, 1'b0);
    rx_power_low_i <= 1'b0;
    wt(2, 1'b0, n);
    cmpn(n - 1, HOLD_N, HOLD_N + 4);
    $display("test loss and interrupt done");
    for (int i = 0; i < 4; i++) begin
      v = $urandom;
      wr(REG_IRQ_MASK, v, RESP_OKAY);
      rd(REG_IRQ_MASK, exp_mask(v), RESP_OKAY);
    end
    s_axi_wstrb_i <= 4'he;
    wr(REG_IRQ_MASK, ~v, RESP_OKAY);
    s_axi_wstrb_i <= 4'hf;
    rd(REG_IRQ_MASK, exp_mask(v), RESP_OKAY);
    rd(REG_IRQ_STAT, 32'h1 << EV_LOS_CLR, RESP_OKAY);
    $display("test random masks done");
    conclude();
  end
endmodule
`default_nettype wire
